// *** gate_driver_defines.svh ***
// constants for the gate driver status and control register bank
`ifndef GATE_DRIVER_DEFINES_SVH
`define GATE_DRIVER_DEFINES_SVH
// ========================================
// serial frame layout
`define FRAME_BITS 5'h10
`define FRAME_OVER 5'h11
`define CMD_BITS 5'h05
`define DATA_MSB_POS 5'h0F
`define RW_POS 15
`define ADDR_HI 14
`define ADDR_LO 11
`define DATA_HI 10
// ========================================
// register addresses
`define ADDR_STATUS_PRI 4'h0
`define ADDR_STATUS_SEC 4'h1
`define ADDR_DRV_CTRL 4'h2
`define ADDR_GATE_HS 4'h3
// ========================================
// field positions, driver control
`define CTL_SCOPE 10
`define CTL_UV_DIS 9
`define CTL_GDE_DIS 8
`define CTL_OVERTEMP_WARN_REPORT 7
`define CTL_MODE_HI 6
`define CTL_MODE_LO 5
`define CTL_RECT 4
`define CTL_DIR 3
`define CTL_COAST 2
`define CTL_BRAKE 1
`define CTL_CLEAR 0
// ========================================
// lock field and reset values
`define LOCK_HI 10
`define LOCK_LO 8
`define LOCK_KEY 3'h6
`define UNLOCK_KEY 3'h3
`define LOCK_RESET 3'h3
`define CTRL_RESET 11'h000
`define STATUS_RESET 11'h000
`define MASK_ALL 11'h7FF
`define MASK_LOCKED 11'h007
`endif

// *** gate_driver_pkg.sv ***
// types shared by the gate driver register bank
package gate_driver_pkg;
    // pwm input mode encodings
    typedef enum logic [1:0] {
        MODE_SIX = 2'h0,
        MODE_THREE = 2'h1,
        MODE_SINGLE = 2'h2,
        MODE_INDEP = 2'h3
    } pwm_mode_t;
endpackage

// *** gate_driver_regs_chk_sva.sv ***
// checker for the gate driver register bank, seen from its ports
`timescale 1ns/1ns
module gate_driver_regs_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdo_oe_o,
    input wire logic [5:0] ds_oc_i,
    input wire logic supply_undervolt_lockout_i,
    input wire logic overtemp_shutdown_i,
    input wire logic phase_c_high_input_i,
    input wire logic phase_c_low_input_i,
    input wire logic error_out_n_pin_o,
    input wire logic [2:0] hb_shutdown_o,
    input gate_driver_pkg::pwm_mode_t pwm_mode_o,
    input wire logic rectify_async_o,
    input wire logic direction_o,
    input wire logic coast_o,
    input wire logic brake_o
);
    // ========================================
    // clocking and sequences
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // single mode held while the brake pin is high
    sequence s_single_brake;
        (pwm_mode_o == gate_driver_pkg::MODE_SINGLE
            && phase_c_low_input_i)[*4];
    endsequence
    // single mode held while the direction pin is high
    sequence s_single_dir;
        (pwm_mode_o == gate_driver_pkg::MODE_SINGLE
            && phase_c_high_input_i)[*4];
    endsequence
    // ========================================
    // assertions
    a_ds_fault_pin: assert property (
        $rose(|ds_oc_i) |-> ##[1:5] !error_out_n_pin_o)
        else $error("fault pin stayed high after overcurrent");
    a_lockout_all_off: assert property (
        (supply_undervolt_lockout_i || overtemp_shutdown_i)[*6]
        |-> hb_shutdown_o == 3'h7)
        else $error("bridges not all off on lockout");
    a_ctrl_after_frame: assert property (
        $changed(pwm_mode_o) || $changed(coast_o)
        |-> spi_cs_n_i && $past(spi_cs_n_i, 2))
        else $error("control output moved inside a frame");
    a_rect_only_single: assert property (
        rectify_async_o |-> pwm_mode_o == gate_driver_pkg::MODE_SINGLE)
        else $error("rectify select outside single mode");
    a_brake_pin_or: assert property (
        s_single_brake |-> brake_o)
        else $error("brake pin ignored in single mode");
    a_dir_pin_or: assert property (
        s_single_dir |-> direction_o)
        else $error("direction pin ignored in single mode");
    a_sdo_released: assert property (
        spi_cs_n_i |-> !spi_sdo_oe_o)
        else $error("data line pulled while deselected");
    a_reset_values: assert property (
        $fell(rst_i) |-> error_out_n_pin_o && hb_shutdown_o == 3'h0
        && !coast_o && !brake_o
        && pwm_mode_o == gate_driver_pkg::MODE_SIX)
        else $error("outputs not at reset values");
endmodule
bind gate_driver_status_control_regs gate_driver_regs_chk i_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_sdo_oe_o(spi_sdo_oe_o),
    .ds_oc_i(ds_oc_i),
    .supply_undervolt_lockout_i(supply_undervolt_lockout_i),
    .overtemp_shutdown_i(overtemp_shutdown_i),
    .phase_c_high_input_i(phase_c_high_input_i),
    .phase_c_low_input_i(phase_c_low_input_i),
    .error_out_n_pin_o(error_out_n_pin_o),
    .hb_shutdown_o(hb_shutdown_o),
    .pwm_mode_o(pwm_mode_o),
    .rectify_async_o(rectify_async_o),
    .direction_o(direction_o),
    .coast_o(coast_o),
    .brake_o(brake_o)
);

// *** gate_driver_status_control_regs.sv ***
// serial register bank: fault status and bridge driver control
// Operation
// (R1) summary bit ORs all faults, mirrors pin
// (R2) status registers read-only, reset to zero
// (R3) primary bits 9-6: overcurrent, gate, supply_undervolt_lockout, overtemp
// (R4) primary bits 5-0 per transistor overcurrent
// (R5) secondary bits 10-8 sense overcurrent A,B,C
// (R6) secondary bit 7 warning, bit 6 supply
// (R7) secondary bits 5-0 per transistor gate error
// (R8) scope bit: one or all half-bridges off
// (R9) bit 9 disables gate supply undervoltage
// (R10) bit 8 disables gate drive error detection
// (R11) bit 7 reports warning on pin, summary
// (R12) bits 6-5 select pwm input mode
// (R13) bit 4 selects rectification in single mode
// (R14) direction is bit 3 OR phase-c high in single mode
// (R15) bit 2 puts all transistors hi-z
// (R16) bit 1 brakes, ORed with phase-c low in single mode
// (R17) bit 0 clears latched faults, self-clears
// (R18) control register read/write, resets to zero
// (R19) 16-bit frame: rw, address, data
// (R20) lock blocks writes except lock, bits 2-0
// (R21) write frame returns previous register contents
// (R22) no sense amps: sense bits read zero
// (R23) latched bits hold; summary updates together
`timescale 1ns/1ns
`include "gate_driver_defines.svh"
module gate_driver_status_control_regs #(
    parameter bit HAS_SENSE_AMP = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    input wire logic [5:0] ds_oc_i,
    input wire logic [5:0] gs_error_i,
    input wire logic [2:0] sense_oc_i,
    input wire logic supply_undervolt_lockout_i,
    input wire logic overtemp_shutdown_i,
    input wire logic overtemp_warning_i,
    input wire logic gate_supply_undervolt_i,
    input wire logic phase_c_high_input_i,
    input wire logic phase_c_low_input_i,
    output logic error_out_n_pin_o,
    output logic [2:0] hb_shutdown_o,
    output gate_driver_pkg::pwm_mode_t pwm_mode_o,
    output logic rectify_async_o,
    output logic direction_o,
    output logic coast_o,
    output logic brake_o
);

    // ========================================
    // elaboration check
    initial begin
        if (HAS_SENSE_AMP !== 1'b0 && HAS_SENSE_AMP !== 1'b1) begin
            $error("HAS_SENSE_AMP must be 0 or 1");
        end
    end

    // ========================================
    // declarations
    logic arm;               // set while chip select idles
    logic [4:0] fall_cnt;    // falling edges seen in frame
    logic [15:0] shift;      // received frame, msb first
    logic [3:0] rd_addr;     // address caught after command
    logic [10:0] rd_word;    // word chosen for readback
    logic [4:0] fall_now;    // edges done, zero at frame start
    logic [3:0] bit_idx;     // data bit being presented
    logic cs_meta;           // first synchroniser stage
    logic cs_sync;           // chip select in clk domain
    logic cs_prev;           // for the rising edge
    logic frame_end;         // one-cycle pulse, two cycles after select rises
    logic [20:0] raw_meta;   // fault pins, first stage
    logic [20:0] raw_sync;   // fault pins, second stage
    logic [10:0] ctrl;       // bridge driver control
    logic [2:0] lock_field;  // register lock field
    logic locked;            // lock engaged
    logic [5:0] ds_flag;     // latched transistor overcurrent
    logic [5:0] gs_flag;     // latched gate drive errors
    logic [2:0] so_flag;     // latched sense overcurrent
    logic supply_undervolt_lockout_q;            // supply lockout, live
    logic overtemp_shutdown_q;            // overtemp shutdown, live
    logic otw_q;             // overtemp warning, live
    logic gate_supply_undervolt_q;            // gate supply undervoltage
    logic fault_q;           // summary bit
    logic [5:0] next_ds;
    logic [5:0] next_gs;
    logic [2:0] next_so;
    logic next_gate_supply_undervolt;
    logic next_fault;
    logic [10:0] status_pri;  // primary status word
    logic [10:0] status_sec;  // secondary status word
    logic [10:0] snap_pri;    // frozen copies for the link
    logic [10:0] snap_sec;
    logic [10:0] snap_ctrl;
    logic [2:0] snap_lock;
    logic wr_take;            // valid write frame
    logic [3:0] wr_addr;
    logic [10:0] wr_data;
    logic [10:0] wr_mask;
    logic [2:0] phase_oc;     // per phase overcurrent
    logic all_off;            // faults that stop every phase
    logic single_mode;
    logic [5:0] ds_in;
    logic [5:0] gs_in;
    logic [2:0] so_in;

    // ========================================
    // link side, on the serial clock
    // idle select presets the frame start marker
    always_ff @(negedge spi_sclk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            arm <= 1'b1;
        end else begin
            arm <= 1'b0;
        end
    end

    // bit counter, saturates so a long frame stays bad
    // (R19) frame counting
    always_ff @(negedge spi_sclk_i or posedge rst_i) begin
        if (rst_i) begin
            fall_cnt <= 5'h00;
        end else if (arm) begin
            fall_cnt <= 5'h01;
        end else if (fall_cnt != `FRAME_OVER) begin
            fall_cnt <= fall_cnt + 5'h01;
        end
    end

    // capture on the falling edge, msb first
    always_ff @(negedge spi_sclk_i or posedge rst_i) begin
        if (rst_i) begin
            shift <= 16'h0000;
        end else begin
            shift <= {shift[14:0], spi_sdi_i};
        end
    end

    // address is complete on the fifth falling edge
    always_ff @(negedge spi_sclk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_addr <= 4'h0;
        end else if (!arm && fall_cnt == (`CMD_BITS - 5'h01)) begin
            rd_addr <= {shift[2:0], spi_sdi_i};
        end
    end

    // readback word from the frozen snapshot
    // (R21) old contents go out, also on writes
    always_comb begin
        unique case (rd_addr)
            `ADDR_STATUS_PRI: rd_word = snap_pri;
            `ADDR_STATUS_SEC: rd_word = snap_sec;
            `ADDR_DRV_CTRL: rd_word = snap_ctrl;
            `ADDR_GATE_HS: rd_word = {snap_lock, 8'h00};
            default: rd_word = 11'h000;
        endcase
    end

    assign fall_now = arm ? 5'h00 : fall_cnt;
    assign bit_idx = 4'(`DATA_MSB_POS - fall_now);

    // open drain: pull low for a zero data bit only
    // first five bits are left released (pulled high)
    always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            spi_sdo_oe_o <= 1'b0;
        end else if (fall_now >= `CMD_BITS &&
                     fall_now <= `DATA_MSB_POS) begin
            spi_sdo_oe_o <= ~rd_word[bit_idx];
        end else begin
            spi_sdo_oe_o <= 1'b0;
        end
    end

    // the driven level is always low
    always_ff @(posedge spi_sclk_i or posedge rst_i) begin
        if (rst_i) begin
            spi_sdo_o <= 1'b0;
        end else begin
            spi_sdo_o <= 1'b0;
        end
    end

    // ========================================
    // crossing into the clk domain
    // select synchroniser; frame words are static once
    // select is high, so the synced rise acts as handshake
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= spi_cs_n_i;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    assign frame_end = cs_sync & ~cs_prev;

    // fault pins come from analog monitors, two stages
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            raw_meta <= 21'h00000;
            raw_sync <= 21'h00000;
        end else begin
            raw_meta <= {ds_oc_i, gs_error_i, sense_oc_i,
                         supply_undervolt_lockout_i,
                         overtemp_shutdown_i, overtemp_warning_i,
                         gate_supply_undervolt_i,
                         phase_c_high_input_i, phase_c_low_input_i};
            raw_sync <= raw_meta;
        end
    end

    assign ds_in = raw_sync[20:15];
    assign gs_in = raw_sync[14:9];
    assign so_in = raw_sync[8:6];

    // ========================================
    // frame decode
    // (R19) exactly sixteen bits, rw low means write
    assign wr_take = frame_end && fall_cnt == `FRAME_BITS &&
                     !shift[`RW_POS];
    assign wr_addr = shift[`ADDR_HI:`ADDR_LO];
    assign wr_data = shift[`DATA_HI:0];
    assign locked = (lock_field == `LOCK_KEY);
    // (R20) locked: only coast, brake, clear may change
    assign wr_mask = locked ? `MASK_LOCKED : `MASK_ALL;

    // ========================================
    // driver control register
    // (R18) read/write, all fields reset to zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= `CTRL_RESET;
        end else if (wr_take && wr_addr == `ADDR_DRV_CTRL) begin
            ctrl <= (ctrl & ~wr_mask) | (wr_data & wr_mask);
        end else begin
            // (R17) clear bit returns to zero by itself
            ctrl[`CTL_CLEAR] <= 1'b0;
        end
    end

    // lock field; keys other than the expected one do nothing
    // (R20) lock field stays writable
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_field <= `LOCK_RESET;
        end else if (wr_take && wr_addr == `ADDR_GATE_HS) begin
            if (!locked &&
                wr_data[`LOCK_HI:`LOCK_LO] == `LOCK_KEY) begin
                lock_field <= `LOCK_KEY;
            end else if (locked &&
                         wr_data[`LOCK_HI:`LOCK_LO] == `UNLOCK_KEY) begin
                lock_field <= `UNLOCK_KEY;
            end
        end
    end

    // ========================================
    // fault latching
    // set wins over clear so no event is lost
    always_comb begin
        // (R17) clear drops latched bits
        // (R23) latched bits otherwise hold
        next_ds = ctrl[`CTL_CLEAR] ? ds_in : (ds_flag | ds_in);
        // (R10) detection gated by the disable bit
        next_gs = ctrl[`CTL_CLEAR] ? 6'h00 : gs_flag;
        next_gs = next_gs | (gs_in & {6{~ctrl[`CTL_GDE_DIS]}});
        // (R22) without sense amps the bits never set
        next_so = ctrl[`CTL_CLEAR] ? 3'h0 : so_flag;
        next_so = next_so | (so_in & {3{HAS_SENSE_AMP}});
        // (R9) undervoltage fault gated by its disable
        next_gate_supply_undervolt = raw_sync[2] & ~ctrl[`CTL_UV_DIS];
        // (R1) summary covers every fault
        // (R11) warning counts only when reported
        next_fault = (|next_ds) | (|next_gs) | (|next_so) |
                     raw_sync[5] | raw_sync[4] | next_gate_supply_undervolt |
                     (raw_sync[3] & ctrl[`CTL_OVERTEMP_WARN_REPORT]);
    end

    // latched and live flags
    // (R2) status flags start at zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ds_flag <= 6'h00;
            gs_flag <= 6'h00;
            so_flag <= 3'h0;
            supply_undervolt_lockout_q <= 1'b0;
            overtemp_shutdown_q <= 1'b0;
            otw_q <= 1'b0;
            gate_supply_undervolt_q <= 1'b0;
        end else begin
            ds_flag <= next_ds;
            gs_flag <= next_gs;
            so_flag <= next_so;
            supply_undervolt_lockout_q <= raw_sync[5];
            overtemp_shutdown_q <= raw_sync[4];
            otw_q <= raw_sync[3];
            gate_supply_undervolt_q <= next_gate_supply_undervolt;
        end
    end

    // summary bit and pin move in the same cycle
    // (R23) same edge as the flags
    // (R1) pin is the inverted summary
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
            error_out_n_pin_o <= 1'b1;
        end else begin
            fault_q <= next_fault;
            error_out_n_pin_o <= ~next_fault;
        end
    end

    // ========================================
    // status words
    // (R3) summary flags of the primary register
    // (R4) per transistor overcurrent in bits 5-0
    assign status_pri = {fault_q, |ds_flag, |gs_flag,
                         supply_undervolt_lockout_q, overtemp_shutdown_q, ds_flag};
    // (R5) sense bits A, B, C in bits 10-8
    // (R6) warning and gate supply flags
    // (R7) per transistor gate errors in bits 5-0
    assign status_sec = {so_flag, otw_q, gate_supply_undervolt_q, gs_flag};

    // snapshot for the link, frozen while select is low
    // the link reads it only after the address arrives
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            snap_pri <= `STATUS_RESET;
            snap_sec <= `STATUS_RESET;
            snap_ctrl <= `CTRL_RESET;
            snap_lock <= `LOCK_RESET;
        end else if (cs_sync) begin
            snap_pri <= status_pri;
            snap_sec <= status_sec;
            snap_ctrl <= ctrl;
            snap_lock <= lock_field;
        end
    end

    // ========================================
    // bridge actions
    // per phase overcurrent, phase A in index 0
    assign phase_oc[0] = ds_flag[5] | ds_flag[4] | so_flag[2];
    assign phase_oc[1] = ds_flag[3] | ds_flag[2] | so_flag[1];
    assign phase_oc[2] = ds_flag[1] | ds_flag[0] | so_flag[0];
    assign all_off = supply_undervolt_lockout_q | overtemp_shutdown_q | gate_supply_undervolt_q | (|gs_flag);

    // half-bridge shutdown
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hb_shutdown_o <= 3'h0;
        end else if (all_off) begin
            hb_shutdown_o <= 3'h7;
        end else if (ctrl[`CTL_SCOPE] && |phase_oc) begin
            // (R8) scope set: every half-bridge stops
            hb_shutdown_o <= 3'h7;
        end else begin
            // (R8) scope clear: affected half-bridge only
            hb_shutdown_o <= phase_oc;
        end
    end

    assign single_mode = (ctrl[`CTL_MODE_HI:`CTL_MODE_LO] ==
                          gate_driver_pkg::MODE_SINGLE);

    // mode and command outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_mode_o <= gate_driver_pkg::MODE_SIX;
            rectify_async_o <= 1'b0;
            direction_o <= 1'b0;
            coast_o <= 1'b0;
            brake_o <= 1'b0;
        end else begin
            // (R12) two-bit mode field
            pwm_mode_o <= gate_driver_pkg::pwm_mode_t'(
                ctrl[`CTL_MODE_HI:`CTL_MODE_LO]);
            // (R13) rectification choice, single mode
            rectify_async_o <= single_mode & ctrl[`CTL_RECT];
            // (R14) direction ORs bit and phase-c high pin, pin in single mode only
            direction_o <= ctrl[`CTL_DIR] |
                           (single_mode & raw_sync[1]);
            // (R15) coast releases all six transistors
            coast_o <= ctrl[`CTL_COAST];
            // (R16) brake ORs bit and phase-c low pin, pin in single mode only
            brake_o <= ctrl[`CTL_BRAKE] |
                       (single_mode & raw_sync[0]);
        end
    end

endmodule

// *** spi_master_model.sv ***
// serial master model driving the register bank frames
`timescale 1ns/1ns
module spi_master_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    // ========================================
    // idle levels: clock low, deselected
    initial begin
        sclk_o = 1'h0;
        cs_n_o = 1'h1;
        sdi_o = 1'h0;
    end
    // ========================================
    // one frame of n bits, 30 ns link clock
    // msb first, n bits, 600 ns gap
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] r);
        // odd offset keeps edges off the system clock
        #7;
        cs_n_o = 1'h0;
        // lead time lets the select pass the synchroniser
        #150;
        for (int i = 15; i > 15 - n; i--) begin
            sclk_o = 1'h1;
            sdi_o = w[i];
            #15;
            // response sampled on the falling edge
            sclk_o = 1'h0;
            r = {r[14:0], sdo_i};
            #15;
        end
        cs_n_o = 1'h1;
        // released line shows the inverse, not a stale bit
        sdi_o = ~sdi_o;
        #600;
    endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the gate driver register bank
`timescale 1ns/1ns
module tb_top;
    // ========================================
    // signals
    logic clk_i;
    logic rst_i;
    logic sclk, cs_n, sdi, sdo, sdo_oe;
    logic [5:0] ds; // overcurrent inputs
    logic [5:0] gs; // gate error inputs
    logic [2:0] so; // sense overcurrent inputs
    logic [5:0] lv; // supply_undervolt_lockout, overtemp_shutdown, otw, gate_supply_undervolt, pin high, pin low
    logic error_out_n_pin_o, rectify_async_o, direction_o;
    logic coast_o, brake_o;
    logic [2:0] hb_shutdown_o;
    gate_driver_pkg::pwm_mode_t pwm_mode_o;
    logic [10:0] ctl; // expected control contents
    logic [15:0] r;
    logic ns_err_n; // fault pin of the copy without sense amps
    logic [2:0] ns_hb; // shutdown of the copy without sense amps
    int num_errors;
    int total_checks;
    // open-drain line with pull-up
    wire sdo_line = sdo_oe ? sdo : 1'h1;
    // ========================================
    // design and far-side master
    gate_driver_status_control_regs i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
        .spi_sdo_oe_o(sdo_oe), .ds_oc_i(ds), .gs_error_i(gs),
        .sense_oc_i(so), .supply_undervolt_lockout_i(lv[5]),
        .overtemp_shutdown_i(lv[4]), .overtemp_warning_i(lv[3]),
        .gate_supply_undervolt_i(lv[2]),
        .phase_c_high_input_i(lv[1]), .phase_c_low_input_i(lv[0]),
        .error_out_n_pin_o(error_out_n_pin_o),
        .hb_shutdown_o(hb_shutdown_o), .pwm_mode_o(pwm_mode_o),
        .rectify_async_o(rectify_async_o), .direction_o(direction_o),
        .coast_o(coast_o), .brake_o(brake_o));
    // second copy without sense amplifiers, watched by its pins
    gate_driver_status_control_regs #(.HAS_SENSE_AMP(1'b0)) i_dut_ns (
        .clk_i(clk_i), .rst_i(rst_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(),
        .spi_sdo_oe_o(), .ds_oc_i(ds), .gs_error_i(gs),
        .sense_oc_i(so), .supply_undervolt_lockout_i(lv[5]),
        .overtemp_shutdown_i(lv[4]), .overtemp_warning_i(lv[3]),
        .gate_supply_undervolt_i(lv[2]),
        .phase_c_high_input_i(lv[1]), .phase_c_low_input_i(lv[0]),
        .error_out_n_pin_o(ns_err_n), .hb_shutdown_o(ns_hb),
        .pwm_mode_o(), .rectify_async_o(), .direction_o(),
        .coast_o(), .brake_o());
    spi_master_model i_master (.sclk_o(sclk), .cs_n_o(cs_n),
        .sdi_o(sdi), .sdo_i(sdo_line));
    // ========================================
    // clock and tasks
    initial begin
        clk_i = 1'h0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input string n, input logic [10:0] seen,
                         input logic [10:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [10:0] d,
                      input logic [10:0] old);
        logic [15:0] q;
        i_master.xfer({1'h0, a, d}, 16, q);
        check("old", q[10:0], old);
    endtask
    task automatic rd(input logic [3:0] a, input logic [10:0] exp);
        logic [15:0] q;
        i_master.xfer({1'h1, a, 11'h000}, 16, q);
        check("reg", q[10:0], exp);
        check("pad", {6'h00, q[15:11]}, 11'h01F);
    endtask
    // clear bit never reads back, so keep it out of the model
    task automatic wr_ctl(input logic [10:0] v);
        wr(4'h2, v, ctl);
        ctl = v & 11'h7FE;
    endtask
    task automatic outs(input logic [10:0] e);
        check("outs", {error_out_n_pin_o, 1'h0, hb_shutdown_o,
            pwm_mode_o, rectify_async_o, direction_o, coast_o,
            brake_o}, e);
    endtask
    task automatic drive(input logic [5:0] d, input logic [5:0] g,
                         input logic [2:0] s, input logic [5:0] l);
        @(posedge clk_i);
        ds <= d;
        gs <= g;
        so <= s;
        lv <= l;
        repeat (8) @(posedge clk_i);
    endtask
    // ========================================
    // watchdog
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
    // ========================================
    // scenarios
    initial begin
        ds = 6'h00; gs = 6'h00; so = 3'h0; lv = 6'h00; ctl = 11'h000;
        num_errors = 0;
        total_checks = 0;
        rst_i = 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        rd(4'h0, 11'h000);
        rd(4'h1, 11'h000);
        rd(4'h2, 11'h000);
        outs(11'h400);
        wr(4'h0, 11'h7FF, 11'h000);
        rd(4'h0, 11'h000);
        wr(4'h5, 11'h123, 11'h000);
        rd(4'h5, 11'h000);
        i_master.xfer({5'h02, 11'h004}, 15, r);
        outs(11'h400);
        // every mode, pins high, bits 4 and 2 set
        drive(6'h00, 6'h00, 3'h0, 6'h03);
        for (logic [2:0] m = 3'h0; m < 3'h4; m++) begin
            wr_ctl({4'h0, m[1:0], 5'h14});
            outs({5'h10, m[1:0], m == 3'h2, m == 3'h2, 1'h1,
                  m == 3'h2});
        end
        wr_ctl(11'h00A);
        drive(6'h00, 6'h00, 3'h0, 6'h00);
        outs(11'h405);
        wr_ctl(11'h000);
        // latched overcurrent, scope, clear
        drive(6'h20, 6'h00, 3'h0, 6'h00);
        outs(11'h040);
        rd(4'h0, 11'h620);
        wr_ctl(11'h400);
        outs(11'h1C0);
        drive(6'h00, 6'h00, 3'h0, 6'h00);
        rd(4'h0, 11'h620);
        wr_ctl(11'h401);
        rd(4'h0, 11'h000);
        outs(11'h400);
        // gate errors, then disabled
        drive(6'h00, 6'h01, 3'h0, 6'h00);
        rd(4'h1, 11'h001);
        rd(4'h0, 11'h500);
        drive(6'h00, 6'h00, 3'h0, 6'h00);
        wr_ctl(11'h001);
        rd(4'h1, 11'h000);
        wr_ctl(11'h100);
        drive(6'h00, 6'h01, 3'h0, 6'h00);
        rd(4'h1, 11'h000);
        drive(6'h00, 6'h00, 3'h0, 6'h00);
        // sense overcurrent on phase a
        drive(6'h00, 6'h00, 3'h4, 6'h00);
        rd(4'h1, 11'h400);
        check("nosense", {7'h00, ns_err_n, ns_hb}, 11'h008);
        drive(6'h00, 6'h00, 3'h0, 6'h00);
        wr_ctl(11'h001);
        // live conditions
        drive(6'h00, 6'h00, 3'h0, 6'h20);
        rd(4'h0, 11'h480);
        outs(11'h1C0);
        drive(6'h00, 6'h00, 3'h0, 6'h10);
        rd(4'h0, 11'h440);
        drive(6'h00, 6'h00, 3'h0, 6'h08);
        rd(4'h1, 11'h080);
        rd(4'h0, 11'h000);
        wr_ctl(11'h080);
        rd(4'h0, 11'h400);
        outs(11'h000);
        drive(6'h00, 6'h00, 3'h0, 6'h04);
        wr_ctl(11'h000);
        rd(4'h1, 11'h040);
        wr_ctl(11'h200);
        rd(4'h1, 11'h000);
        drive(6'h00, 6'h00, 3'h0, 6'h00);
        wr_ctl(11'h000);
        // lock lets only coast, brake and clear through
        wr(4'h3, 11'h600, 11'h300);
        wr(4'h2, 11'h7FE, 11'h000);
        rd(4'h2, 11'h006);
        wr(4'h3, 11'h300, 11'h600);
        ctl = 11'h006;
        wr_ctl(11'h000);
        finish_test();
    end
endmodule
